/* File: rac_defs.svh */
// Offsets, field positions, reset values and counts of the alarm control block
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH

// Register byte offsets
`define RAC_OFS_CTRL      8'h00
`define RAC_OFS_IRQ_STAT  8'h04
`define RAC_OFS_IRQ_EN    8'h08
`define RAC_OFS_IRQ_CLR   8'h0C

// Alarm control field positions
`define RAC_BIT_ENABLE    15
`define RAC_BIT_CHIME     14
`define RAC_BIT_PIV       13
`define RAC_BIT_SYNC      12
`define RAC_INT_HI        11
`define RAC_INT_LO        8
`define RAC_RPT_HI        7
`define RAC_RPT_LO        0

// Repeat counter limits
`define RAC_RPT_MAX       8'hFF
`define RAC_RPT_ZERO      8'h00
`define RAC_RPT_ONE       8'h01

// Prescaler distance that still counts as near a rollover, in RTC clocks
`define RAC_SYNC_WINDOW   32
`define RAC_PRESCALE_W    15

// Interrupt status layout
`define RAC_IRQ_W         2
`define RAC_IRQ_EVT       0
`define RAC_IRQ_AUTOOFF   1

// Reset values
`define RAC_CTRL_RESET    32'h0000_0000
`define RAC_IRQ_RESET     2'h0

`endif

/* File: rac_pkg.sv */
// Types shared by the alarm control block
`include "rac_defs.svh"

package rac_pkg;

  // Alarm interval codes; codes above the yearly one are reserved
  typedef enum logic [3:0] {
    RAC_IV_HALF_SEC = 4'b0000,
    RAC_IV_SECOND   = 4'b0001,
    RAC_IV_TEN_SEC  = 4'b0010,
    RAC_IV_MINUTE   = 4'b0011,
    RAC_IV_TEN_MIN  = 4'b0100,
    RAC_IV_HOUR     = 4'b0101,
    RAC_IV_DAY      = 4'b0110,
    RAC_IV_WEEK     = 4'b0111,
    RAC_IV_MONTH    = 4'b1000,
    RAC_IV_YEAR     = 4'b1001
  } rac_interval_type;

  // Calendar side signals seen by the alarm logic
  typedef struct packed {
    logic                          on;
    logic                          half_roll;
    logic [`RAC_PRESCALE_W-1:0]    prescale;
    logic [9:0]                    match;
    logic                          alarm_feb29;
    logic                          leap_year;
  } rac_cal_type;

  // Alarm state carried into the readable domain
  typedef struct packed {
    logic       alarm_enable;
    logic [7:0] alarm_repeat_count;
  } rac_state_type;

endpackage : rac_pkg

/* File: rac_sync2.sv */
// Two-stage synchroniser for the readable copy of the alarm state
`timescale 1ns/10ps
`default_nettype none

module rac_sync2 #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // Width refused at elaboration
  if (WIDTH < 1)
  begin : g_bad_width
    $error("rac_sync2: WIDTH must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // rac_sync2

`default_nettype wire

/* File: rac_alarm_ctrl.sv */
// Alarm control register and alarm sequencing of the calendar unit
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.svh"

// How it works
// - Alarm events occur only while alarm_enable is set.
// - With chime on, the repeat count wraps from 00 to FF.
// - With chime off, the repeat count stops at 00.
// - Pulse initial value is writable while alarms are disabled.
// - While enabled, pulse value writes are ignored; reads show pulse level.
// - Sync flag is high within 32 RTC clocks of a half-second rollover.
// - Repeat count and enable reach the read path through synchronisers.
// - Four-bit interval code selects the alarm period; 1010 and up reserved.
// - Yearly alarm on February 29 fires only in leap years.
// - Event at count 00 with chime off clears alarm_enable.
// - The register resets only on power-on reset.
module rac_alarm_ctrl
  import rac_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int SYNC_WINDOW = `RAC_SYNC_WINDOW
) (
  // APB clock and power-on reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Calendar side
  input  wire rac_pkg::rac_cal_type cal,
  // Alarm outputs
  output var  logic                alarm_pulse,
  output var  logic                irq
);

  import rac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks, refused at elaboration
  if (SYNC_WINDOW < 1 || SYNC_WINDOW >= (1 << `RAC_PRESCALE_W))
  begin : g_bad_window
    $error("rac_alarm_ctrl: SYNC_WINDOW out of range");
  end
  if (ADDR_W < 4)
  begin : g_bad_addr
    $error("rac_alarm_ctrl: ADDR_W too small for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Reserved interval codes never produce an event
  function automatic logic interval_reserved(input logic [3:0] sel);
    interval_reserved = (sel > RAC_IV_YEAR);
  endfunction

  // Interval match for the selected period
  function automatic logic interval_hit(input logic [3:0] sel, input rac_cal_type c);
    logic hit;
    hit = 1'b0;
    if (interval_reserved(sel))
    begin
      hit = 1'b0;
    end
    else if (sel == RAC_IV_YEAR)
    begin
      hit = c.match[9] && (!c.alarm_feb29 || c.leap_year);
    end
    else
    begin
      hit = c.match[sel];
    end
    interval_hit = hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                      en_q;
  logic                      en_d;
  logic                      chime_q;
  logic                      chime_d;
  logic                      pulse_q;
  logic                      pulse_d;
  logic [3:0]                int_q;
  logic [3:0]                int_d;
  logic [7:0]                rpt_q;
  logic [7:0]                rpt_d;
  logic                      sync_flag_q;
  logic [`RAC_IRQ_W-1:0]     stat_q;
  logic [`RAC_IRQ_W-1:0]     stat_d;
  logic [`RAC_IRQ_W-1:0]     irq_en_q;
  logic [31:0]               prdata_q;
  rac_state_type             live_state;
  rac_state_type             read_state;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire hit_ctrl   = (paddr == ADDR_W'(`RAC_OFS_CTRL));
  wire hit_stat   = (paddr == ADDR_W'(`RAC_OFS_IRQ_STAT));
  wire hit_en     = (paddr == ADDR_W'(`RAC_OFS_IRQ_EN));
  wire hit_clr    = (paddr == ADDR_W'(`RAC_OFS_IRQ_CLR));
  wire addr_hit   = hit_ctrl || hit_stat || hit_en || hit_clr;
  wire setup_ph   = psel && !penable;
  wire access_ph  = psel && penable;
  wire wr_acc     = access_ph && pwrite && addr_hit;
  wire wr_ctrl    = wr_acc && hit_ctrl;
  wire wr_irq_en  = wr_acc && hit_en;
  wire wr_irq_clr = wr_acc && hit_clr;

  // Zero wait states; read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_hit;
  assign prdata  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm event and its consequences
  wire alarm_evt = en_q && cal.on && cal.half_roll && interval_hit(int_q, cal);
  wire rpt_zero  = (rpt_q == `RAC_RPT_ZERO);
  wire auto_off  = alarm_evt && rpt_zero && !chime_q;
  wire rpt_step  = alarm_evt && !(rpt_zero && !chime_q);

  // A software write wins over the same-cycle hardware update
  assign en_d    = wr_ctrl ? pwdata[`RAC_BIT_ENABLE] : (auto_off ? 1'b0 : en_q);
  assign chime_d = wr_ctrl ? pwdata[`RAC_BIT_CHIME] : chime_q;
  assign int_d   = wr_ctrl ? pwdata[`RAC_INT_HI:`RAC_INT_LO] : int_q;
  // Decrement wraps 00 to FF naturally when chime allows it
  assign rpt_d   = wr_ctrl  ? pwdata[`RAC_RPT_HI:`RAC_RPT_LO] :
                   rpt_step ? rpt_q - `RAC_RPT_ONE : rpt_q;
  // Initial pulse level only accepted while alarms are off
  assign pulse_d = (wr_ctrl && !en_q) ? pwdata[`RAC_BIT_PIV] :
                   alarm_evt          ? ~pulse_q : pulse_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; presetn is the power-on reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q    <= 1'b0;
      chime_q <= 1'b0;
      pulse_q <= 1'b0;
      int_q   <= 4'h0;
      rpt_q   <= `RAC_RPT_ZERO;
    end
    else
    begin
      en_q    <= en_d;
      chime_q <= chime_d;
      pulse_q <= pulse_d;
      int_q   <= int_d;
      rpt_q   <= rpt_d;
    end
  end

  assign alarm_pulse = pulse_q;

  ////////////////////////////////////////////////////////////////////////////
  // Rollover proximity; prescaler counts up to all ones then rolls
  wire [`RAC_PRESCALE_W-1:0] to_roll  = {`RAC_PRESCALE_W{1'b1}} - cal.prescale;
  wire                       near_roll = (to_roll <= `RAC_PRESCALE_W'(SYNC_WINDOW));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_flag_q <= 1'b0;
    end
    else
    begin
      sync_flag_q <= near_roll;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readable copy of enable and repeat count, two stages behind
  assign live_state.alarm_enable       = en_q;
  assign live_state.alarm_repeat_count = rpt_q;

  rac_sync2 #(
    .WIDTH ($bits(rac_state_type))
  ) u_state_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (live_state),
    .dout    (read_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over a same-cycle clear
  wire [`RAC_IRQ_W-1:0] irq_set = {auto_off, alarm_evt};
  wire [`RAC_IRQ_W-1:0] irq_clr = wr_irq_clr ? pwdata[`RAC_IRQ_W-1:0] : '0;

  assign stat_d = (stat_q & ~irq_clr) | irq_set;
  assign irq    = |(stat_q & irq_en_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q   <= `RAC_IRQ_RESET;
      irq_en_q <= `RAC_IRQ_RESET;
    end
    else
    begin
      stat_q   <= stat_d;
      irq_en_q <= wr_irq_en ? pwdata[`RAC_IRQ_W-1:0] : irq_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux; clear register reads as zero
  wire [31:0] ctrl_rd = {16'h0000,
                         read_state.alarm_enable,
                         chime_q,
                         pulse_q,
                         sync_flag_q,
                         int_q,
                         read_state.alarm_repeat_count};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_stat ? {30'h0, stat_q} :
                        hit_en   ? {30'h0, irq_en_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_ph && !pwrite)
    begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_disabled_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_q && !wr_ctrl) |=> $stable(pulse_q) && $stable(rpt_q))
    else $error("alarm state moved while alarms disabled");

  a_chime_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_evt && chime_q && rpt_zero && !wr_ctrl) |=> (rpt_q == `RAC_RPT_MAX))
    else $error("repeat count did not wrap to FF");

  a_count_stops: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_evt && !chime_q && rpt_zero && !wr_ctrl) |=> (rpt_q == `RAC_RPT_ZERO))
    else $error("repeat count moved past zero");

  a_piv_taken: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !en_q) |=> (pulse_q == $past(pwdata[`RAC_BIT_PIV])))
    else $error("pulse initial value not taken");

  a_piv_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && en_q && !alarm_evt) |=> $stable(pulse_q))
    else $error("pulse value changed by write while enabled");

  a_sync_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ((cal.prescale < {`RAC_PRESCALE_W{1'b1}} - `RAC_PRESCALE_W'(SYNC_WINDOW)) ##1 1'b1)
      |-> !sync_flag_q)
    else $error("sync flag high far from rollover");

  a_read_delay: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 (read_state.alarm_repeat_count == $past(rpt_q, 2)))
    else $error("readable repeat count not two stages behind");

  a_reserved_code: assert property (@(posedge pclk) disable iff (!presetn)
    (int_q >= 4'hA && !wr_ctrl) |=> $stable(pulse_q) && $stable(rpt_q))
    else $error("event on reserved interval code");

  a_leap_only: assert property (@(posedge pclk) disable iff (!presetn)
    (int_q == RAC_IV_YEAR && cal.alarm_feb29 && !cal.leap_year && !wr_ctrl)
      |=> $stable(pulse_q))
    else $error("February 29 alarm fired outside leap year");

  a_auto_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_evt && rpt_zero && !chime_q && !wr_ctrl) |=> !en_q ##1 !alarm_evt)
    else $error("alarm enable not cleared at last repeat");

  a_pulse_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_evt && !wr_ctrl && !rpt_zero) |=> (pulse_q != $past(pulse_q))
      && (rpt_q == $past(rpt_q) - `RAC_RPT_ONE))
    else $error("event did not toggle pulse and step count");

  // Enable and configuration only move by a write or an alarm event
  a_en_written: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (en_q == $past(pwdata[`RAC_BIT_ENABLE])))
    else $error("alarm enable write not taken");

  a_cal_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!cal.on && !wr_ctrl) |=> $stable(pulse_q) && $stable(rpt_q))
    else $error("alarm state moved while calendar off");

  a_chime_keeps_on: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_evt && chime_q && !wr_ctrl) |=> en_q)
    else $error("chime alarm stopped");

  a_config_kept: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(chime_q) && $stable(int_q))
    else $error("alarm configuration lost without a write");

  a_count_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (!alarm_evt && !wr_ctrl) |=> $stable(rpt_q))
    else $error("repeat count moved without an event");

  a_year_fires: assert property (@(posedge pclk) disable iff (!presetn)
    (en_q && cal.on && cal.half_roll && cal.match[9] && int_q == RAC_IV_YEAR
      && cal.leap_year && !wr_ctrl) |=> (pulse_q != $past(pulse_q)))
    else $error("yearly alarm missed in leap year");

  // Read path two stages behind, flag raised ahead of the rollover
  a_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 (read_state.alarm_enable == $past(en_q, 2)))
    else $error("readable enable not two stages behind");

  a_sync_near: assert property (@(posedge pclk) disable iff (!presetn)
    (cal.prescale >= {`RAC_PRESCALE_W{1'b1}} - `RAC_PRESCALE_W'(SYNC_WINDOW))
      |=> sync_flag_q)
    else $error("sync flag low near rollover");

  // Interrupt status bits follow their events
  a_evt_flagged: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_evt |=> stat_q[`RAC_IRQ_EVT])
    else $error("alarm event not recorded in status");

  a_off_flagged: assert property (@(posedge pclk) disable iff (!presetn)
    auto_off |=> stat_q[`RAC_IRQ_AUTOOFF])
    else $error("auto disable not recorded in status");

  a_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_irq_clr && pwdata[`RAC_IRQ_EVT] && !alarm_evt) |=> !stat_q[`RAC_IRQ_EVT])
    else $error("event status not cleared");

endmodule // rac_alarm_ctrl

`default_nettype wire

/* File: rac_tb.sv */
// Self-checking testbench for the alarm control block
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.svh"

module testbench;
  import rac_pkg::*;

  //////////////////////////////////////////////////////////////////////
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rac_cal_type cal;
  logic        alarm_pulse;
  logic        irq;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic [31:0] rd0;
  logic        er;
  logic        p;

  // Block under test, only one clock domain here
  rac_alarm_ctrl #(.ADDR_W(8), .SYNC_WINDOW(32)) DUT (
    .pclk        (pclk),
    .presetn     (presetn),
    .paddr       (paddr),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .cal         (cal),
    .alarm_pulse (alarm_pulse),
    .irq         (irq)
  );

  // 50 MHz bus clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the hang guard
  task automatic wrap_up;
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t value mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Control write, then let the synchronised copy settle (3 edges)
  task automatic wctl(input logic en, input logic ch, input logic pv,
                      input logic [3:0] iv, input logic [7:0] c);
    apb(1'b1, `RAC_OFS_CTRL, {16'h0000, en, ch, pv, 1'b0, iv, c});
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // One half-second rollover with the given match vector
  task automatic evt(input logic [9:0] m);
    @(posedge pclk);
    cal.match     <= m;
    cal.half_roll <= 1'b1;
    @(posedge pclk);
    cal.half_roll <= 1'b0;
    cal.match     <= 10'h000;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Enable and repeat count fields of the control word
  task automatic rdcnt(input logic [31:0] exp);
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_80FF, exp);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(rd, `RAC_CTRL_RESET);
    apb(1'b0, `RAC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({30'h0, alarm_pulse, irq}, 32'h0000_0000);
    chk(32'(pready), 32'h1);
  endtask

  task automatic t_pulse_init;
    wctl(1'b0, 1'b0, 1'b1, RAC_IV_SECOND, 8'h00);
    chk(32'(alarm_pulse), 32'h1);
    wctl(1'b0, 1'b0, 1'b0, RAC_IV_SECOND, 8'h00);
    chk(32'(alarm_pulse), 32'h0);
    wctl(1'b1, 1'b0, 1'b0, RAC_IV_SECOND, 8'h05);
    wctl(1'b1, 1'b0, 1'b1, RAC_IV_SECOND, 8'h05);
    chk(32'(alarm_pulse), 32'h0);
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(32'(rd[13]), 32'h0);
    evt(10'h002);
    chk(32'(alarm_pulse), 32'h1);
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(32'(rd[13]), 32'h1);
    chk(rd & 32'h0000_80FF, 32'h0000_8004);
  endtask

  // Last alarm without chime, then interrupt status, mask and clear
  task automatic t_last_alarm;
    wctl(1'b0, 1'b0, 1'b0, RAC_IV_SECOND, 8'h00);
    apb(1'b1, `RAC_OFS_IRQ_CLR, 32'h0000_0003);
    wctl(1'b1, 1'b0, 1'b0, RAC_IV_SECOND, 8'h01);
    evt(10'h002);
    chk(32'(alarm_pulse), 32'h1);
    rdcnt(32'h0000_8000);
    evt(10'h002);
    chk(32'(alarm_pulse), 32'h0);
    rdcnt(32'h0000_0000);
    evt(10'h002);
    chk(32'(alarm_pulse), 32'h0);
    apb(1'b0, `RAC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk(32'(irq), 32'h0);
    apb(1'b1, `RAC_OFS_IRQ_EN, 32'h0000_0002);
    chk(32'(irq), 32'h1);
    apb(1'b1, `RAC_OFS_IRQ_CLR, 32'h0000_0001);
    apb(1'b0, `RAC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, `RAC_OFS_IRQ_EN, 32'h0000_0001);
    chk(32'(irq), 32'h0);
    apb(1'b1, `RAC_OFS_IRQ_CLR, 32'h0000_0002);
    apb(1'b0, `RAC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `RAC_OFS_IRQ_CLR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
  endtask

  // Chime lets the count wrap below zero
  task automatic t_chime;
    wctl(1'b1, 1'b1, 1'b0, RAC_IV_HALF_SEC, 8'h00);
    evt(10'h001);
    rdcnt(32'h0000_80FF);
    evt(10'h001);
    rdcnt(32'h0000_80FE);
    @(posedge pclk);
    cal.on <= 1'b0;
    evt(10'h001);
    rdcnt(32'h0000_80FE);
    @(posedge pclk);
    cal.on <= 1'b1;
  endtask

  // Every interval code, a wrong match, and the reserved codes
  task automatic t_codes;
    for (int c = 0; c < 16; c++)
    begin
      wctl(1'b1, 1'b1, 1'b0, 4'(c), 8'h10);
      p = alarm_pulse;
      if (c < 10)
      begin
        evt(10'(1) << ((c + 1) % 10));
        chk(32'(alarm_pulse), 32'(p));
        evt(10'(1) << c);
        chk(32'(alarm_pulse), 32'(!p));
      end
      else
      begin
        evt(10'h3FF);
        chk(32'(alarm_pulse), 32'(p));
      end
    end
  endtask

  // Yearly alarm on the leap day
  task automatic t_leap;
    @(posedge pclk);
    cal.alarm_feb29 <= 1'b1;
    cal.leap_year   <= 1'b0;
    wctl(1'b1, 1'b1, 1'b0, RAC_IV_YEAR, 8'h05);
    p = alarm_pulse;
    evt(10'h200);
    chk(32'(alarm_pulse), 32'(p));
    @(posedge pclk);
    cal.leap_year <= 1'b1;
    evt(10'h200);
    chk(32'(alarm_pulse), 32'(!p));
  endtask

  // Read flag at both sides of the 32-clock boundary
  task automatic t_sync;
    @(posedge pclk);
    cal.prescale <= 15'h7FDF;
    repeat (2) @(posedge pclk);
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(32'(rd[12]), 32'h1);
    // Flag high: reread until two reads agree
    rd0 = rd;
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    while (rd !== rd0)
    begin
      rd0 = rd;
      apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    end
    chk(rd & 32'h0000_80FF, 32'h0000_8004);
    @(posedge pclk);
    cal.prescale <= 15'h7FDE;
    repeat (2) @(posedge pclk);
    apb(1'b0, `RAC_OFS_CTRL, 32'h0000_0000);
    chk(32'(rd[12]), 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    cal     = '0;
    cal.on  = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pulse_init();
    t_last_alarm();
    t_chime();
    t_codes();
    t_leap();
    t_sync();
    wrap_up();
  end

endmodule // testbench
`default_nettype wire
